/* design/phc_top.sv */
// packet handling engine with apb configuration registers
`timescale 1ns/1ns
// Operation
// - sync low byte register supplies sync pattern bits 7:0.
// - sync high byte register supplies sync pattern bits 15:8.
// - fixed mode uses frame size register as exact payload length, reset 0xff.
// - variable mode uses frame size register as maximum accepted length.
// - drop_on_check_fail set discards a fixed or variable length packet whose crc fails, only while crc_en is set.
// - add_rx_trailer appends signal strength and crc-ok bytes, reset on.
// - address_filter_mode: off, exact, plus 0x00, plus 0x00 and 0xff.
// - data_path_format 00 moves data through fifos.
// - synchronous serial: tx in on pin zero, rx out on output pins.
// - format 10 sends pn9 random data, receives as normal.
// - asynchronous serial: tx in on pin zero, rx out on output pins.
// - length field 00 selects fixed length from frame size register.
// - length field 01 takes length from first byte after sync.
// - length field 10 runs unbounded packets; 11 is reserved.
// - received address compared with node address, 0x00/0xff broadcast.
// - channel index times spacing added to base frequency.
// - rx subtracts xtal/1024 times intermediate_freq_word from base plus channel offset.
module phc_top
  import phc_pkg::*;
#(
  parameter int FREQ_W = 24,
  parameter int SPACE_W = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [FREQ_W-1:0] base_freq_i,
  input wire logic [SPACE_W-1:0] channel_index_spacing_i,
  output logic [FREQ_W-1:0] synth_freq_o,
  output logic [FREQ_W-1:0] rx_mixer_freq_o,
  output logic [15:0] sync_word_o,
  input wire logic rx_start_i,
  input wire phc_byte_s rx_byte_i,
  input wire logic [7:0] rssi_i,
  input wire logic rx_crc_ok_i,
  output phc_byte_s rx_fifo_wr_o,
  output logic rx_flush_o,
  output logic rx_drop_o,
  input wire phc_byte_s tx_fifo_byte_i,
  input wire logic tx_bit_req_i,
  output logic tx_bit_o,
  output logic crc_tx_en_o,
  input wire logic general_pin_zero_i,
  input wire logic rx_bit_i,
  output logic general_output_pins_o
);
  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (FREQ_W < 18 || SPACE_W < 1 || SPACE_W + 8 > FREQ_W) begin : g_chk
    $error("phc_top: frequency widths unusable");
  end

  function automatic logic [7:0] lo8(input logic [31:0] w);
    return w[7:0];
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] sync_hi_q, sync_lo_q, frame_size_register_q;
  logic [7:0] ctrl1_q, ctrl0_q, addr_q, channel_index_q, if_q;
  logic [7:0] stat_q;
  logic acc;
  logic known;
  assign acc = psel_i & penable_i;
  assign known = paddr_i[1:0] == 2'b00 && paddr_i[7:2] <= PHC_OFF_STAT[5:0];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_hi_q <= PHC_RST_SYNC_HI;
      sync_lo_q <= PHC_RST_SYNC_LO;
      frame_size_register_q <= PHC_RST_LEN;
      ctrl1_q <= PHC_RST_CTRL1;
      ctrl0_q <= PHC_RST_CTRL0;
      addr_q <= PHC_RST_ADDR;
      channel_index_q <= PHC_RST_CHANNEL_INDEX;
      if_q <= PHC_RST_IF;
    end else if (acc && pwrite_i && paddr_i[1:0] == 2'b00) begin
      unique case (paddr_i[7:2])
        PHC_OFF_SYNC_HI[5:0]: sync_hi_q <= lo8(pwdata_i);
        PHC_OFF_SYNC_LO[5:0]: sync_lo_q <= lo8(pwdata_i);
        // zero is illegal for the host; stored as written
        PHC_OFF_LEN[5:0]: frame_size_register_q <= lo8(pwdata_i);
        PHC_OFF_CTRL1[5:0]: ctrl1_q <= lo8(pwdata_i) & PHC_MASK_CTRL1;
        PHC_OFF_CTRL0[5:0]: ctrl0_q <= lo8(pwdata_i) & PHC_MASK_CTRL0;
        PHC_OFF_ADDR[5:0]: addr_q <= lo8(pwdata_i);
        PHC_OFF_CHANNEL_INDEX[5:0]: channel_index_q <= lo8(pwdata_i);
        PHC_OFF_IF[5:0]: if_q <= lo8(pwdata_i) & PHC_MASK_IF;
        default: ;
      endcase
    end
  end

  // zero-wait slave; misaligned or above 0x30 gets pslverr
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~known;
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i && known) begin
        unique case (paddr_i[7:2])
          PHC_OFF_SYNC_HI[5:0]: prdata_o[7:0] <= sync_hi_q;
          PHC_OFF_SYNC_LO[5:0]: prdata_o[7:0] <= sync_lo_q;
          PHC_OFF_LEN[5:0]: prdata_o[7:0] <= frame_size_register_q;
          PHC_OFF_CTRL1[5:0]: prdata_o[7:0] <= ctrl1_q;
          PHC_OFF_CTRL0[5:0]: prdata_o[7:0] <= ctrl0_q;
          PHC_OFF_ADDR[5:0]: prdata_o[7:0] <= addr_q;
          PHC_OFF_CHANNEL_INDEX[5:0]: prdata_o[7:0] <= channel_index_q;
          PHC_OFF_IF[5:0]: prdata_o[7:0] <= if_q;
          PHC_OFF_STAT[5:0]: prdata_o[7:0] <= stat_q;
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // decoded fields
  // ------------------------------------------------------------
  logic drop_on_check_fail, add_rx_trailer, crc_en;
  logic [1:0] address_filter_mode;
  phc_fmt_e data_path_format;
  phc_len_e len_mode;
  logic [4:0] intermediate_freq_word;
  assign drop_on_check_fail = ctrl1_q[PHC_BIT_FLUSH];
  assign add_rx_trailer = ctrl1_q[PHC_BIT_APPEND];
  assign address_filter_mode = ctrl1_q[1:0];
  assign data_path_format = phc_fmt_e'(ctrl0_q[5:4]);
  assign crc_en = ctrl0_q[PHC_BIT_CRC_EN];
  assign len_mode = phc_len_e'(ctrl0_q[1:0]);
  assign intermediate_freq_word = if_q[4:0];

  function automatic logic addr_pass(input logic [1:0] m,
                                     input logic [7:0] a,
                                     input logic [7:0] own);
    logic p;
    p = 1'b1;
    unique case (m)
      2'b00: p = 1'b1;
      2'b01: p = a == own;
      2'b10: p = a == own || a == PHC_BCAST_ZERO;
      2'b11: p = a == own || a == PHC_BCAST_ZERO || a == PHC_BCAST_ONES;
    endcase
    return p;
  endfunction

  // ------------------------------------------------------------
  // frequency words
  // ------------------------------------------------------------
  logic [FREQ_W-1:0] channel_index_off;
  logic [FREQ_W-1:0] if_off;
  // widen before the product so high channel bits are not lost
  assign channel_index_off = FREQ_W'(channel_index_q) * FREQ_W'(channel_index_spacing_i);
  // fif = fxtal/2^10 * word, i.e. word << 6 in fxtal/2^16 units
  assign if_off = FREQ_W'({intermediate_freq_word, 6'b000000});
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      synth_freq_o <= '0;
      rx_mixer_freq_o <= '0;
      sync_word_o <= {PHC_RST_SYNC_HI, PHC_RST_SYNC_LO};
    end else begin
      synth_freq_o <= base_freq_i + channel_index_off;
      rx_mixer_freq_o <= base_freq_i + channel_index_off - if_off;
      sync_word_o <= {sync_hi_q, sync_lo_q};
    end
  end

  // ------------------------------------------------------------
  // receive packet engine
  // ------------------------------------------------------------
  phc_state_e st_q;
  logic [7:0] remain_q;
  logic [1:0] tail_q;
  logic inf_q;
  logic addr_due_q;
  logic fifo_path;
  assign fifo_path = data_path_format == PHC_FMT_FIFO ||
                     data_path_format == PHC_FMT_PN9;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= PHC_ST_IDLE;
      remain_q <= 8'h00;
      tail_q <= 2'b00;
      inf_q <= 1'b0;
      addr_due_q <= 1'b0;
      rx_fifo_wr_o <= '0;
      rx_flush_o <= 1'b0;
      rx_drop_o <= 1'b0;
      stat_q <= 8'h00;
    end else begin
      rx_fifo_wr_o <= '0;
      rx_flush_o <= 1'b0;
      rx_drop_o <= 1'b0;
      unique case (st_q)
        PHC_ST_IDLE: begin
          if (rx_start_i && fifo_path) begin
            addr_due_q <= address_filter_mode != 2'b00;
            inf_q <= len_mode == PHC_LEN_INF;
            remain_q <= frame_size_register_q;
            if (len_mode == PHC_LEN_VAR) begin
              st_q <= PHC_ST_LEN;
            end else if (len_mode == PHC_LEN_RSVD) begin
              st_q <= PHC_ST_IDLE;
            end else begin
              st_q <= PHC_ST_BODY;
            end
          end
        end
        PHC_ST_LEN: begin
          if (rx_byte_i.valid) begin
            // oversize or zero length packets are refused
            if (rx_byte_i.data > frame_size_register_q ||
                rx_byte_i.data == 8'h00) begin
              st_q <= PHC_ST_IDLE;
              rx_drop_o <= 1'b1;
            end else begin
              remain_q <= rx_byte_i.data;
              rx_fifo_wr_o <= rx_byte_i;
              st_q <= PHC_ST_BODY;
            end
          end
        end
        PHC_ST_BODY: begin
          if (rx_byte_i.valid) begin
            rx_fifo_wr_o <= rx_byte_i;
            if (!inf_q) begin
              remain_q <= remain_q - 8'h01;
              if (remain_q == 8'h01) begin
                st_q <= PHC_ST_TAIL;
                tail_q <= 2'b00;
              end
            end
            // last, so a rejected one-byte packet never reaches the tail
            if (addr_due_q) begin
              addr_due_q <= 1'b0;
              if (!addr_pass(address_filter_mode, rx_byte_i.data,
                             addr_q)) begin
                st_q <= PHC_ST_IDLE;
                rx_flush_o <= 1'b1;
                rx_drop_o <= 1'b1;
              end
            end
          end
          if (rx_start_i && inf_q && !rx_byte_i.valid) begin
            st_q <= PHC_ST_IDLE;
          end
        end
        PHC_ST_TAIL: begin
          stat_q <= {rx_crc_ok_i | ~crc_en, 7'h00};
          if (crc_en && drop_on_check_fail && !rx_crc_ok_i) begin
            rx_flush_o <= 1'b1;
            rx_drop_o <= 1'b1;
            st_q <= PHC_ST_IDLE;
          end else if (!add_rx_trailer) begin
            st_q <= PHC_ST_IDLE;
          end else begin
            tail_q <= tail_q + 2'b01;
            rx_fifo_wr_o.valid <= 1'b1;
            if (tail_q == 2'b00) begin
              rx_fifo_wr_o.data <= rssi_i;
            end else begin
              rx_fifo_wr_o.data <= (rx_crc_ok_i | ~crc_en) ?
                                   PHC_STAT_OK : 8'h00;
              st_q <= PHC_ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // transmit bit source and serial paths
  // ------------------------------------------------------------
  logic [8:0] pn9_q;
  logic [2:0] bit_idx_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pn9_q <= PHC_PN9_SEED;
      bit_idx_q <= 3'd7;
      tx_bit_o <= 1'b0;
      crc_tx_en_o <= 1'b0;
      general_output_pins_o <= 1'b0;
    end else begin
      crc_tx_en_o <= crc_en & fifo_path;
      general_output_pins_o <= 1'b0;
      if (data_path_format == PHC_FMT_SYNC ||
          data_path_format == PHC_FMT_ASYNC) begin
        tx_bit_o <= general_pin_zero_i;
        general_output_pins_o <= rx_bit_i;
      end else if (tx_bit_req_i) begin
        if (data_path_format == PHC_FMT_PN9) begin
          tx_bit_o <= pn9_q[0];
          pn9_q <= {pn9_q[0] ^ pn9_q[5], pn9_q[8:1]};
        end else begin
          tx_bit_o <= tx_fifo_byte_i.data[bit_idx_q];
          bit_idx_q <= bit_idx_q - 3'd1;
        end
      end
    end
  end
endmodule

/* design/phc_pkg.sv */
// package: register map, field layout and types of the packet config block
package phc_pkg;
  localparam logic [7:0] PHC_OFF_SYNC_HI = 8'h04;
  localparam logic [7:0] PHC_OFF_SYNC_LO = 8'h05;
  localparam logic [7:0] PHC_OFF_LEN = 8'h06;
  localparam logic [7:0] PHC_OFF_CTRL1 = 8'h07;
  localparam logic [7:0] PHC_OFF_CTRL0 = 8'h08;
  localparam logic [7:0] PHC_OFF_ADDR = 8'h09;
  localparam logic [7:0] PHC_OFF_CHANNEL_INDEX = 8'h0a;
  localparam logic [7:0] PHC_OFF_IF = 8'h0b;
  localparam logic [7:0] PHC_OFF_STAT = 8'h0c;
  localparam logic [7:0] PHC_RST_SYNC_HI = 8'hd3;
  localparam logic [7:0] PHC_RST_SYNC_LO = 8'h91;
  localparam logic [7:0] PHC_RST_LEN = 8'hff;
  localparam logic [7:0] PHC_RST_CTRL1 = 8'h04;
  localparam logic [7:0] PHC_RST_CTRL0 = 8'h45;
  localparam logic [7:0] PHC_RST_ADDR = 8'h00;
  localparam logic [7:0] PHC_RST_CHANNEL_INDEX = 8'h00;
  localparam logic [7:0] PHC_RST_IF = 8'h0f;
  localparam logic [7:0] PHC_MASK_CTRL1 = 8'hef;
  localparam logic [7:0] PHC_MASK_CTRL0 = 8'h77;
  localparam logic [7:0] PHC_MASK_IF = 8'h3f;
  localparam int PHC_BIT_FLUSH = 3;
  localparam int PHC_BIT_APPEND = 2;
  localparam int PHC_BIT_CRC_EN = 2;
  localparam logic [7:0] PHC_BCAST_ZERO = 8'h00;
  localparam logic [7:0] PHC_BCAST_ONES = 8'hff;
  localparam logic [8:0] PHC_PN9_SEED = 9'h1ff;
  localparam logic [15:0] PHC_CRC_SEED = 16'hffff;
  localparam logic [15:0] PHC_CRC_POLY = 16'h8005;
  localparam logic [7:0] PHC_STAT_OK = 8'h80;

  typedef enum logic [1:0] {
    PHC_LEN_FIXED = 2'b00,
    PHC_LEN_VAR = 2'b01,
    PHC_LEN_INF = 2'b10,
    PHC_LEN_RSVD = 2'b11
  } phc_len_e;

  typedef enum logic [1:0] {
    PHC_FMT_FIFO = 2'b00,
    PHC_FMT_SYNC = 2'b01,
    PHC_FMT_PN9 = 2'b10,
    PHC_FMT_ASYNC = 2'b11
  } phc_fmt_e;

  typedef enum logic [3:0] {
    PHC_ST_IDLE = 4'b0001,
    PHC_ST_LEN = 4'b0010,
    PHC_ST_BODY = 4'b0100,
    PHC_ST_TAIL = 4'b1000
  } phc_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } phc_apb_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } phc_byte_s;
endpackage

/* verif/phc_host.sv */
// apb host model that programs the configuration registers
`timescale 1ns/1ns
module phc_host
  import phc_pkg::*;
(
  input wire logic clk_i,
  output phc_apb_req_s req_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  logic to_q = 1'b0;
  initial req_o = '0;
  // ----------------------------------------
  // one transfer, held until pready
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    req_o <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    req_o.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (!pready_i && n < 64);
    to_q = (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    req_o.psel <= 1'b0;
    req_o.penable <= 1'b0;
    // released data flips so a stale word never looks live
    req_o.pwdata <= ~d;
  endtask
endmodule

/* verif/phc_top_sva_sva.sv */
// assertions on the bus port and configured outputs
`timescale 1ns/1ns
module phc_top_sva
  import phc_pkg::*;
#(
  parameter int FREQ_W = 24,
  parameter int SPACE_W = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [FREQ_W-1:0] base_freq_i,
  input wire logic [SPACE_W-1:0] channel_index_spacing_i,
  input wire logic [FREQ_W-1:0] synth_freq_o,
  input wire logic [FREQ_W-1:0] rx_mixer_freq_o,
  input wire logic [15:0] sync_word_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic wr;
  logic [15:0] sw_q;
  logic [7:0] ch_q;
  logic [4:0] if_q;
  logic [FREQ_W-1:0] syn_x;
  assign wr = psel_i && penable_i && pready_o && pwrite_i;
  assign syn_x = base_freq_i + FREQ_W'(ch_q) * FREQ_W'(channel_index_spacing_i);
  // ----------------------------------------
  // shadows, so checks need no bus reads
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sw_q <= 16'hd391;
    end else if (wr && paddr_i == 8'h10) begin
      sw_q[15:8] <= pwdata_i[7:0];
    end else if (wr && paddr_i == 8'h14) begin
      sw_q[7:0] <= pwdata_i[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ch_q <= 8'h00;
    end else if (wr && paddr_i == 8'h28) begin
      ch_q <= pwdata_i[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      if_q <= 5'h0f;
    end else if (wr && paddr_i == 8'h2c) begin
      if_q <= pwdata_i[4:0];
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ready_next: assert property (psel_i && !penable_i |=> pready_o)
    else $error("ready late");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready too long");
  a_bad_addr: assert property (psel_i && !penable_i &&
      (paddr_i[1:0] != 2'h0 || paddr_i > 8'h30) |=> pslverr_o &&
      prdata_o == 32'h0)
    else $error("stray address taken");
  a_sync_low: assert property (
      wr && paddr_i == 8'h14 |-> ##[1:2] sync_word_o[7:0] == sw_q[7:0])
    else $error("sync low stale");
  a_sync_high: assert property (
      wr && paddr_i == 8'h10 |-> ##[1:2] sync_word_o[15:8] == sw_q[15:8])
    else $error("sync high stale");
  a_ctrl_read: assert property (psel_i && penable_i && pready_o &&
      !pwrite_i && paddr_i == 8'h1c |-> prdata_o[31:8] == 24'h0 &&
      !prdata_o[4])
    else $error("unused bit reads one");
  a_channel_index_freq: assert property (
      wr && paddr_i == 8'h28 |-> ##[1:3] synth_freq_o == syn_x)
    else $error("synth word wrong");
  a_if_mixer: assert property (
      wr && paddr_i == 8'h2c |-> ##[1:3]
      rx_mixer_freq_o == synth_freq_o - (FREQ_W'(if_q) << 6))
    else $error("mixer word wrong");
endmodule

bind phc_top phc_top_sva #(.FREQ_W(FREQ_W), .SPACE_W(SPACE_W)) u_sva (
  .clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .prdata_o, .pready_o, .pslverr_o, .base_freq_i, .channel_index_spacing_i,
  .synth_freq_o, .rx_mixer_freq_o, .sync_word_o
);

/* verif/tb.sv */
// testbench for the packet handling configuration block
`timescale 1ns/1ns
module tb;
  import phc_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  phc_apb_req_s req;
  logic [31:0] prdata;
  logic pready, pslverr, flush, drop, crc_en, gout, tx_bit;
  logic tx_req = 1'b0;
  logic pin0 = 1'b0;
  phc_byte_s tx_byte = '0;
  logic [15:0] space = 16'h0fff;
  logic [15:0] lb = 16'h0000;
  logic [23:0] base = 24'h100000;
  logic [23:0] synth, mix;
  logic [15:0] sync_w;
  logic rx_start = 1'b0;
  logic crc_ok = 1'b1;
  logic rx_bit = 1'b0;
  phc_byte_s rx_byte = '0;
  phc_byte_s wr_b;
  int err_count = 0;
  int check_count = 0;
  int nw, nf, nd, dw, df, dd;
  logic [7:0] ra [8] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28,
    8'h2c};
  logic [7:0] rv [8] = '{8'hd3, 8'h91, 8'hff, 8'h04, 8'h45, 8'h00, 8'h00,
    8'h0f};
  logic [7:0] rm [8] = '{8'hff, 8'hff, 8'hff, 8'hef, 8'h77, 8'hff, 8'hff,
    8'h3f};
  logic [7:0] ad [4] = '{8'h42, 8'h00, 8'hff, 8'h13};
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    nw += int'(wr_b.valid === 1'b1);
    nf += int'(flush === 1'b1);
    nd += int'(drop === 1'b1);
    if (wr_b.valid === 1'b1) lb = {lb[7:0], wr_b.data};
  end
  phc_host u_host (.clk_i, .req_o(req), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr));
  phc_top u_dut (.clk_i, .sys_rst_i, .psel_i(req.psel),
    .penable_i(req.penable), .pwrite_i(req.pwrite), .paddr_i(req.paddr),
    .pwdata_i(req.pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .base_freq_i(base), .channel_index_spacing_i(space),
    .synth_freq_o(synth), .rx_mixer_freq_o(mix), .sync_word_o(sync_w),
    .rx_start_i(rx_start), .rx_byte_i(rx_byte), .rssi_i(8'h5a),
    .rx_crc_ok_i(crc_ok), .rx_fifo_wr_o(wr_b), .rx_flush_o(flush),
    .rx_drop_o(drop), .tx_fifo_byte_i(tx_byte), .tx_bit_req_i(tx_req),
    .tx_bit_o(tx_bit), .crc_tx_en_o(crc_en), .general_pin_zero_i(pin0),
    .rx_bit_i(rx_bit), .general_output_pins_o(gout));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    err_count += int'(u_host.to_q);
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic io(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [31:0] q, output logic e);
    u_host.xfer(w, a, {24'h0, d}, q, e);
    if (u_host.to_q) report_and_stop;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    io(1'b1, a, d, q, e);
  endtask
  // crc level is fixed before the bytes; idle gap keeps lengths honest
  task automatic pkt(input logic [7:0] b[$], input logic ok);
    int w0, f0, d0;
    w0 = nw;
    f0 = nf;
    d0 = nd;
    crc_ok <= ok;
    rx_start <= 1'b1;
    @(posedge clk_i);
    rx_start <= 1'b0;
    foreach (b[i]) begin
      @(posedge clk_i);
      rx_byte <= '{valid: 1'b1, data: b[i]};
      @(posedge clk_i);
      rx_byte.valid <= 1'b0;
    end
    repeat (12) @(posedge clk_i);
    dw = nw - w0;
    df = nf - f0;
    dd = nd - d0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    chk(32'(sync_w), 32'hd391);
    foreach (ra[i]) begin
      io(1'b0, ra[i], 8'h00, q, e);
      chk(q, 32'(rv[i]));
      wr(ra[i], (i == 4) ? 8'hf6 : 8'hff);
      io(1'b0, ra[i], 8'h00, q, e);
      chk(q, 32'(((i == 4) ? 8'hf6 : 8'hff) & rm[i]));
      wr(ra[i], rv[i]);
    end
    io(1'b0, 8'h34, 8'h00, q, e);
    chk({q[30:0], e}, 32'h1);
    io(1'b1, 8'h15, 8'h00, q, e);
    chk(32'(e), 32'h1);
    wr(8'h10, 8'ha5);
    wr(8'h14, 8'h3c);
    wr(8'h20, 8'h41);
    repeat (3) @(posedge clk_i);
    chk(32'(sync_w), 32'ha53c);
    chk(32'(crc_en), 32'h0);
    wr(8'h20, 8'h45);
    repeat (3) @(posedge clk_i);
    chk(32'(crc_en), 32'h1);
    $display("regs done");
  endtask
  task automatic t_freq;
    logic [23:0] x;
    base <= 24'h200000;
    wr(8'h28, 8'hff);
    wr(8'h2c, 8'h1f);
    repeat (4) @(posedge clk_i);
    x = base + 24'd255 * 24'(space);
    chk(32'(synth), 32'(x));
    chk(32'(mix), 32'(x - (24'h1f << 6)));
    $display("freq done");
  endtask
  task automatic t_filter;
    bit ok;
    wr(8'h24, 8'h42);
    for (int m = 0; m < 4; m++) begin
      wr(8'h1c, 8'(m));
      foreach (ad[k]) begin
        pkt('{8'h02, ad[k], 8'h11}, 1'b1);
        ok = m == 0 || k == 0 || (k == 1 && m > 1) || (k == 2 && m == 3);
        chk(32'(dd), 32'(!ok));
      end
    end
    $display("filter done");
  endtask
  task automatic t_len;
    logic [31:0] q;
    logic e;
    wr(8'h1c, 8'h00);
    wr(8'h18, 8'h05);
    pkt('{8'h06}, 1'b1);
    chk(32'(dd), 32'h1);
    pkt('{8'h05, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05}, 1'b1);
    chk(32'(dd), 32'h0);
    wr(8'h20, 8'h44);
    wr(8'h18, 8'h03);
    pkt('{8'h01, 8'h02, 8'h03}, 1'b1);
    chk(32'(dw), 32'h3);
    wr(8'h1c, 8'h04);
    pkt('{8'h01, 8'h02, 8'h03}, 1'b1);
    chk(32'(dw), 32'h5);
    chk(32'(lb), {16'h0, 8'h5a, PHC_STAT_OK});
    io(1'b0, 8'h30, 8'h00, q, e);
    chk(q, 32'(PHC_STAT_OK));
    wr(8'h1c, 8'h08);
    pkt('{8'h01, 8'h02, 8'h03}, 1'b0);
    chk(32'(df), 32'h1);
    wr(8'h1c, 8'h00);
    pkt('{8'h01, 8'h02, 8'h03}, 1'b0);
    chk(32'(df), 32'h0);
    $display("length done");
  endtask
  // n bit requests, one per edge; each bit is read one edge after its launch
  task automatic txrun(input int n, output logic [11:0] s);
    s = '0;
    tx_req <= 1'b1;
    for (int i = 0; i <= n; i++) begin
      @(posedge clk_i);
      if (i > 0) s = {s[10:0], tx_bit};
      if (i == n - 1) tx_req <= 1'b0;
    end
  endtask
  task automatic t_tx;
    logic [11:0] s;
    tx_byte <= '{valid: 1'b1, data: 8'hb4};
    wr(8'h20, 8'h44);
    txrun(8, s);
    chk(32'(s), 32'h0b4);
    // all-ones seed: nine ones come out before the first zero
    wr(8'h20, 8'h64);
    txrun(12, s);
    chk(32'(s), 32'hff8);
    chk(32'(crc_en), 32'h1);
    $display("tx done");
  endtask
  task automatic t_serial;
    for (int f = 1; f < 4; f += 2) begin
      wr(8'h20, 8'(8'h44 | (f << 4)));
      rx_bit <= 1'b1;
      pin0 <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(32'(gout), 32'h1);
      chk(32'(tx_bit), 32'h0);
      rx_bit <= 1'b0;
      pin0 <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk(32'(gout), 32'h0);
      chk(32'(tx_bit), 32'h1);
    end
    $display("serial done");
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_freq;
    t_filter;
    t_len;
    t_tx;
    t_serial;
    report_and_stop;
  end
endmodule
